//--- verilog/otpr_pkg.sv
// Notes on behaviour
// - bit 7 of pattern-high (03h) turns the test pattern on at 1, off at 0.
// - bit 6 of pattern-high has no function; writes to it are ignored.
// - pattern-high bits 5 to 0 give pattern data bits 11 down to 6.
// - pattern-low (04h) bits 7 to 2 give pattern data bits 5 down to 0.
// - pattern-low bits 1 and 0 give the two extra compatibility bits.
// - a 1 in the soft reset bit clears all mode registers and self-clears.
// - the output mode picks lanes and word length; 010 is two lanes of 12.
package otpr_pkg;

    // ------------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------------
    localparam logic [6:0] OTPR_ADDR_RESET  = 7'h00;
    localparam logic [6:0] OTPR_ADDR_POWER  = 7'h01;
    localparam logic [6:0] OTPR_ADDR_OUTMOD = 7'h02;
    localparam logic [6:0] OTPR_ADDR_PATHI  = 7'h03;
    localparam logic [6:0] OTPR_ADDR_PATLO  = 7'h04;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int         OTPR_RESET_BIT   = 7;
    localparam int         OTPR_ENABLE_BIT  = 7;
    localparam logic [7:0] OTPR_PATHI_MASK  = 8'hbf;
    localparam logic [7:0] OTPR_REG_RESET   = 8'h00;
    localparam int         OTPR_FRAME_BITS  = 16;

    // ------------------------------------------------------------------
    // output mode codes (low three bits of the output mode register)
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OTPR_MODE_2L16 = 3'b000,
        OTPR_MODE_2L14 = 3'b001,
        OTPR_MODE_2L12 = 3'b010,
        OTPR_MODE_1L14 = 3'b101,
        OTPR_MODE_1L16 = 3'b110,
        OTPR_MODE_1L16B = 3'b111
    } otpr_mode_type;

    typedef struct packed {
        logic        enable;
        logic [11:0] word;
        logic [1:0]  extra;
    } otpr_pattern_type;

    typedef struct packed {
        logic [2:0] lanes;
        logic [4:0] bits;
    } otpr_format_type;

endpackage

//--- verilog/otpr_serializer.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// per-channel word serializer, one or two lanes, msb first
// ----------------------------------------------------------------------
module otpr_serializer
    import otpr_pkg::*;
(
    input  wire logic            clock,
    input  wire logic            rst_n,
    input  wire logic            frame_start,
    input  wire logic [15:0]     word,
    input  wire otpr_format_type fmt,
    output logic [1:0]           lane_out
);
    logic [15:0] shift_r;
    logic [15:0] shift_nxt;
    logic [1:0]  lane_nxt;

    always_comb begin
        shift_nxt = shift_r;
        lane_nxt  = 2'b00;
        if (frame_start) begin
            // align the word to the top so the msb goes first
            shift_nxt = word << (5'd16 - fmt.bits);
        end
        if (fmt.lanes == 3'd2) begin
            lane_nxt  = shift_nxt[15:14];
            shift_nxt = {shift_nxt[13:0], 2'b00};
        end else begin
            lane_nxt  = {1'b0, shift_nxt[15]};
            shift_nxt = {shift_nxt[14:0], 1'b0};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shift_r  <= 16'h0000;
            lane_out <= 2'b00;
        end else begin
            shift_r  <= shift_nxt;
            lane_out <= lane_nxt;
        end
    end
endmodule

//--- verilog/otpr_regs.sv
`timescale 1ns/1ps
module otpr_regs
    import otpr_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        cfg_write,
    input  wire logic [6:0]  cfg_addr,
    input  wire logic [7:0]  cfg_wdata,
    input  wire logic        cfg_read,
    input  wire logic [11:0] conv_a,
    input  wire logic [11:0] conv_b,
    output logic [7:0]       cfg_rdata,
    output logic             pattern_output_enable,
    output logic [2:0]       serializer_lane_format,
    output logic [1:0]       lanes_a,
    output logic [1:0]       lanes_b,
    output logic             frame_r
);
    // ------------------------------------------------------------------
    // mode registers
    // ------------------------------------------------------------------
    logic [7:0] power_r;
    logic [7:0] power_nxt;
    logic [7:0] outmod_r;
    logic [7:0] outmod_nxt;
    logic [7:0] pathi_r;
    logic [7:0] pathi_nxt;
    logic [7:0] patlo_r;
    logic [7:0] patlo_nxt;
    logic [7:0] rdata_nxt;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // one strobe per register; the compare lives in one place so that
    // reset and register writes can never decode an address differently
    function automatic logic hit(input logic       req,
                                 input logic [6:0] addr,
                                 input logic [6:0] want);
        return req && (addr == want);
    endfunction

    logic       soft_reset;
    logic       wr_power;
    logic       wr_outmod;
    logic       wr_pathi;
    logic       wr_patlo;
    assign soft_reset = hit(cfg_write, cfg_addr, OTPR_ADDR_RESET)
                        && cfg_wdata[OTPR_RESET_BIT];
    assign wr_power   = hit(cfg_write, cfg_addr, OTPR_ADDR_POWER);
    assign wr_outmod  = hit(cfg_write, cfg_addr, OTPR_ADDR_OUTMOD);
    assign wr_pathi   = hit(cfg_write, cfg_addr, OTPR_ADDR_PATHI);
    assign wr_patlo   = hit(cfg_write, cfg_addr, OTPR_ADDR_PATLO);

    // ------------------------------------------------------------------
    // mode register next state
    // ------------------------------------------------------------------
    always_comb begin
        power_nxt  = power_r;
        outmod_nxt = outmod_r;
        pathi_nxt  = pathi_r;
        patlo_nxt  = patlo_r;
        if (soft_reset) begin
            // the reset bit is write only and holds no state of its own
            power_nxt  = OTPR_REG_RESET;
            outmod_nxt = OTPR_REG_RESET;
            pathi_nxt  = OTPR_REG_RESET;
            patlo_nxt  = OTPR_REG_RESET;
        end
        if (wr_power) begin
            power_nxt = cfg_wdata;
        end
        if (wr_outmod) begin
            outmod_nxt = cfg_wdata;
        end
        if (wr_pathi) begin
            // bit 6 is dropped on the way in, so a read never shows it
            pathi_nxt = cfg_wdata & OTPR_PATHI_MASK;
        end
        if (wr_patlo) begin
            patlo_nxt = cfg_wdata;
        end
    end

    // ------------------------------------------------------------------
    // read data: held until the next read, unmapped addresses read zero
    // ------------------------------------------------------------------
    always_comb begin
        rdata_nxt = cfg_rdata;
        if (cfg_read) begin
            unique case (cfg_addr)
                OTPR_ADDR_POWER:  rdata_nxt = power_r;
                OTPR_ADDR_OUTMOD: rdata_nxt = outmod_r;
                OTPR_ADDR_PATHI:  rdata_nxt = pathi_r;
                OTPR_ADDR_PATLO:  rdata_nxt = patlo_r;
                default:          rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            power_r  <= OTPR_REG_RESET;
            outmod_r <= OTPR_REG_RESET;
            pathi_r  <= OTPR_REG_RESET;
            patlo_r  <= OTPR_REG_RESET;
        end else begin
            power_r  <= power_nxt;
            outmod_r <= outmod_nxt;
            pathi_r  <= pathi_nxt;
            patlo_r  <= patlo_nxt;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata <= 8'h00;
        end else begin
            cfg_rdata <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // pattern assembly and format decode
    // ------------------------------------------------------------------
    otpr_pattern_type pat;
    otpr_format_type  fmt;

    always_comb begin
        pat.enable = pathi_r[OTPR_ENABLE_BIT];
        pat.word   = {pathi_r[5:0], patlo_r[7:2]};
        pat.extra  = patlo_r[1:0];
    end

    function automatic otpr_format_type decode_fmt(input logic [2:0] code);
        otpr_format_type f;
        f = '{lanes: 3'd2, bits: 5'd16};
        unique case (code)
            OTPR_MODE_2L16: f = '{lanes: 3'd2, bits: 5'd16};
            OTPR_MODE_2L14: f = '{lanes: 3'd2, bits: 5'd14};
            OTPR_MODE_2L12: f = '{lanes: 3'd2, bits: 5'd12};
            OTPR_MODE_1L14: f = '{lanes: 3'd1, bits: 5'd14};
            OTPR_MODE_1L16,
            OTPR_MODE_1L16B: f = '{lanes: 3'd1, bits: 5'd16};
            // unused codes fall back to the reset format
            default:        f = '{lanes: 3'd2, bits: 5'd16};
        endcase
        return f;
    endfunction

    // words are the top n bits of a 16-bit frame: 12 data bits, two extras, zero padding
    function automatic logic [15:0] frame_word(input logic [11:0] d,
                                               input logic [1:0]  x,
                                               input logic [4:0]  n);
        logic [15:0] w;
        w = {d, x, 2'b00};
        return w >> (5'd16 - n);
    endfunction

    always_comb fmt = decode_fmt(outmod_r[2:0]);

    // ------------------------------------------------------------------
    // frame timing: new word every frame of serial cycles
    // ------------------------------------------------------------------
    logic [4:0] bit_cnt_r;
    logic [4:0] bit_cnt_nxt;
    logic [4:0] frame_len;
    logic       frame_nxt;
    assign frame_len = (fmt.lanes == 3'd2) ? (fmt.bits >> 1) : fmt.bits;

    // >= rather than == so a mode change that shortens the frame while
    // the count is already past the new end still wraps at once
    always_comb begin
        frame_nxt   = 1'b0;
        bit_cnt_nxt = bit_cnt_r + 5'd1;
        if (bit_cnt_r >= frame_len - 5'd1) begin
            bit_cnt_nxt = 5'd0;
            frame_nxt   = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_r <= 5'd0;
            frame_r   <= 1'b0;
        end else begin
            bit_cnt_r <= bit_cnt_nxt;
            frame_r   <= frame_nxt;
        end
    end

    logic [15:0] word_a;
    logic [15:0] word_b;
    always_comb begin
        // test pattern replaces both channels at once
        if (pat.enable) begin
            word_a = frame_word(pat.word, pat.extra, fmt.bits);
            word_b = frame_word(pat.word, pat.extra, fmt.bits);
        end else begin
            word_a = frame_word(conv_a, 2'b00, fmt.bits);
            word_b = frame_word(conv_b, 2'b00, fmt.bits);
        end
    end

    otpr_serializer u_ser_a (
        .clock       (clock),
        .rst_n       (rst_n),
        .frame_start (frame_nxt),
        .word        (word_a),
        .fmt         (fmt),
        .lane_out    (lanes_a)
    );

    otpr_serializer u_ser_b (
        .clock       (clock),
        .rst_n       (rst_n),
        .frame_start (frame_nxt),
        .word        (word_b),
        .fmt         (fmt),
        .lane_out    (lanes_b)
    );

    // status copies straight from flip-flops
    assign pattern_output_enable  = pathi_r[OTPR_ENABLE_BIT];
    assign serializer_lane_format = outmod_r[2:0];
endmodule

//--- verif/otpr_regs_assertions.sv
`timescale 1ns/1ps
// --------
// port checker with shadow pattern registers
// --------
module otpr_regs_assertions
    import otpr_pkg::*;
(
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       cfg_write,
    input wire logic [6:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic       cfg_read,
    input wire logic [7:0] cfg_rdata,
    input wire logic       pattern_output_enable,
    input wire logic [2:0] serializer_lane_format,
    input wire logic [1:0] lanes_a,
    input wire logic [1:0] lanes_b,
    input wire logic       frame_r
);
    logic [7:0] hi_r;
    logic [7:0] lo_r;
    logic [4:0] q_r;
    logic [4:0] gap_r;
    logic [4:0] same_r;
    logic [2:0] fmt_q_r;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // q_r counts quiet cycles so frames latched before a write are skipped;
    // gap_r counts cycles since the last frame marker and same_r how long
    // the output mode has stood, so frame length is judged on its own
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hi_r    <= 8'h00;
            lo_r    <= 8'h00;
            q_r     <= 5'h00;
            gap_r   <= 5'h00;
            same_r  <= 5'h00;
            fmt_q_r <= 3'h0;
        end else begin
            q_r     <= cfg_write ? 5'h00 : q_r + {4'h0, q_r != 5'h1f};
            gap_r   <= frame_r ? 5'h01 : gap_r + {4'h0, gap_r != 5'h1f};
            fmt_q_r <= serializer_lane_format;
            same_r  <= (serializer_lane_format != fmt_q_r) ? 5'h00
                       : same_r + {4'h0, same_r != 5'h1f};
            if (cfg_write && cfg_addr == OTPR_ADDR_RESET && cfg_wdata[7]) begin
                hi_r <= 8'h00;
                lo_r <= 8'h00;
            end
            if (cfg_write && cfg_addr == OTPR_ADDR_PATHI) begin
                hi_r <= cfg_wdata & 8'hbf;
            end
            if (cfg_write && cfg_addr == OTPR_ADDR_PATLO) begin
                lo_r <= cfg_wdata;
            end
        end
    end
    chk_enable_write: assert property (
        cfg_write && cfg_addr == OTPR_ADDR_PATHI
        |=> pattern_output_enable == $past(cfg_wdata[7]))
        else $error("pattern enable does not follow the write");
    chk_mode_write: assert property (
        cfg_write && cfg_addr == OTPR_ADDR_OUTMOD
        |=> serializer_lane_format == $past(cfg_wdata[2:0]))
        else $error("output mode does not follow the write");
    chk_soft_clear: assert property (
        cfg_write && cfg_addr == 7'h00 && cfg_wdata[7]
        |=> !pattern_output_enable && serializer_lane_format == 3'h0)
        else $error("soft reset left a mode register set");
    chk_high_read: assert property (
        cfg_read && cfg_addr == OTPR_ADDR_PATHI
        |=> cfg_rdata == $past(hi_r))
        else $error("pattern high read back wrong");
    chk_low_read: assert property (
        cfg_read && cfg_addr == OTPR_ADDR_PATLO
        |=> cfg_rdata == $past(lo_r))
        else $error("pattern low read back wrong");
    chk_frame_len: assert property (
        frame_r && serializer_lane_format == 3'h2 && same_r >= 5'd8
        && $stable(serializer_lane_format)
        |-> gap_r == 5'd6)
        else $error("twelve bit frame is not six cycles");
    chk_lanes_same: assert property (
        pattern_output_enable && q_r > 5'd20
        |-> lanes_a == lanes_b)
        else $error("channels differ while the pattern is on");
    chk_pattern_top: assert property (
        frame_r && pattern_output_enable
        && serializer_lane_format == 3'h2 && q_r > 5'd20
        |-> lanes_a == hi_r[5:4]
        ##1 (q_r == 5'h00 || lanes_a == hi_r[3:2]))
        else $error("pattern top bits wrong on the lanes");
endmodule

//--- verif/otpr_rx.sv
`timescale 1ns/1ps
// --------
// one-channel receiver, 2-lane 12-bit mode
// --------
module otpr_rx (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        frame_r,
    input  wire logic [1:0]  lanes,
    output logic      [11:0] word
);
    logic [11:0] shift_r;
    // a word is only known complete when the next marker shows
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shift_r <= 12'h000;
            word    <= 12'h000;
        end else if (frame_r) begin
            shift_r <= {10'h000, lanes};
            word    <= shift_r;
        end else begin
            shift_r <= {shift_r[9:0], lanes};
        end
    end
endmodule

//--- verif/output_test_pattern_regs_tb_top.sv
`timescale 1ns/1ps
module output_test_pattern_regs_tb_top;
    import otpr_pkg::*;
    logic        clock = 1'b0, rst_n = 1'b0, cfg_write = 1'b0, cfg_read = 1'b0;
    logic [6:0]  cfg_addr = 7'h00;
    logic [7:0]  cfg_wdata = 8'h00, cfg_rdata, hi, lo;
    logic [11:0] conv_a = 12'h000, conv_b = 12'h000, rx_word, rx_word_b;
    logic        pattern_output_enable, frame_r;
    logic [2:0]  serializer_lane_format;
    logic [1:0]  lanes_a, lanes_b;
    int          err_count = 0, tests_run = 0, gap;
    always #20 clock = ~clock;
    otpr_regs u_otpr_regs (.clock, .rst_n, .cfg_write, .cfg_addr, .cfg_wdata,
        .cfg_read, .conv_a, .conv_b, .cfg_rdata, .pattern_output_enable,
        .serializer_lane_format, .lanes_a, .lanes_b, .frame_r);
    otpr_rx u_otpr_rx (.clock, .rst_n, .frame_r, .lanes(lanes_a),
        .word(rx_word));
    otpr_rx u_otpr_rx_b (.clock, .rst_n, .frame_r, .lanes(lanes_b),
        .word(rx_word_b));
    // --------
    // tasks
    // --------
    function automatic logic [11:0] exp_word(logic [7:0] h, l, logic [11:0] c);
        return h[7] ? {h[5:0], l[7:2]} : c;
    endfunction
    // cycles per word: bits over lanes; unused codes act as two lanes of 16
    function automatic int exp_gap(input int m);
        case (3'(m))
            OTPR_MODE_2L14: return 7;
            OTPR_MODE_2L12: return 6;
            OTPR_MODE_1L14: return 14;
            OTPR_MODE_1L16, OTPR_MODE_1L16B: return 16;
            default: return 8;
        endcase
    endfunction
    task automatic frame_gap(output int n);
        n = 0;
        @(posedge clock);
        #1;
        while (!frame_r) begin
            @(posedge clock);
            #1;
        end
        do begin
            @(posedge clock);
            #1 n++;
        end while (!frame_r);
    endtask
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clock);
        #1 {cfg_write, cfg_addr, cfg_wdata} = {1'b1, a, d};
        @(posedge clock);
        #1 cfg_write = 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        @(posedge clock);
        #1 {cfg_read, cfg_addr} = {1'b1, a};
        @(posedge clock);
        #1 cfg_read = 1'b0;
        check({4'h0, cfg_rdata}, {4'h0, exp});
    endtask
    task automatic finish_test;
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        finish_test;
    end
    initial begin
        void'($urandom(95000));
        repeat (5) @(posedge clock);
        #1 rst_n = 1'b1;
        rd(OTPR_ADDR_PATHI, 8'h00);
        rd(OTPR_ADDR_PATLO, 8'h00);
        wr(OTPR_ADDR_OUTMOD, 8'h02);
        for (int i = 0; i < 6; i++) begin
            hi = 8'($urandom);
            lo = 8'($urandom);
            if (i < 2) begin
                hi = i ? 8'hc0 : 8'hff;
                lo = i ? 8'h03 : 8'hfc;
            end
            hi[7] = !i[0];
            conv_a = 12'($urandom);
            conv_b = 12'($urandom);
            wr(OTPR_ADDR_PATHI, hi);
            wr(OTPR_ADDR_PATLO, lo);
            rd(OTPR_ADDR_PATHI, hi & 8'hbf);
            rd(OTPR_ADDR_PATLO, lo);
            check(12'(pattern_output_enable), 12'(hi[7]));
            repeat (40) @(posedge clock);
            #1 check(rx_word, exp_word(hi, lo, conv_a));
            check(rx_word_b, exp_word(hi, lo, conv_b));
        end
        wr(OTPR_ADDR_PATHI, 8'hab);
        for (int m = 0; m < 8; m++) begin
            wr(OTPR_ADDR_OUTMOD, 8'(m));
            check(12'(serializer_lane_format), 12'(m));
            repeat (20) @(posedge clock);
            frame_gap(gap);
            check(12'(gap), 12'(exp_gap(m)));
        end
        wr(OTPR_ADDR_RESET, 8'h80);
        check(12'(pattern_output_enable), 12'h000);
        check(12'(serializer_lane_format), 12'h000);
        rd(OTPR_ADDR_RESET, 8'h00);
        rd(OTPR_ADDR_PATHI, 8'h00);
        rd(OTPR_ADDR_PATLO, 8'h00);
        rd(7'h05, 8'h00);
        finish_test;
    end
endmodule
bind otpr_regs otpr_regs_assertions u_otpr_regs_assertions (.clock, .rst_n,
    .cfg_write, .cfg_addr, .cfg_wdata, .cfg_read, .cfg_rdata,
    .pattern_output_enable, .serializer_lane_format, .lanes_a, .lanes_b,
    .frame_r);
